// ===== logic/tbt_cfg.svh
`ifndef TBT_CFG_SVH
`define TBT_CFG_SVH
// Purpose: Named constants for the touch baseline tracking block.
// Assumes: All signal values are 16 bits wide.
// Notes: Gain shifts set the threshold offset as a fraction of the reference.
`define TBT_WIDTH 16
`define TBT_CONFIRM 4
`define TBT_SHIFT_HIGH 6
`define TBT_SHIFT_MED 5
`define TBT_SHIFT_LOW 4
`define TBT_UP_STEP 1
`define TBT_DN_STEP 4
`define TBT_UP_INTERVAL 16
`define TBT_DN_INTERVAL 1
`define TBT_INTERVAL_MAX 256
`define TBT_ZERO16 16'h0000
`define TBT_MAX16 16'hffff
`define TBT_CNT_ZERO 8'h00
`define TBT_CONF_ZERO 3'h0
`endif

// ===== logic/tbt_pkg.sv
// Purpose: Types shared by the touch baseline tracking block.
// Assumes: Nothing beyond the configuration header.
// Notes: Gain levels order from most to least sensitive.
package tbt_pkg;
  typedef enum logic [1:0] {GAIN_HIGH, GAIN_MED, GAIN_LOW} tbt_gain_t;
  typedef enum logic {ST_CAL, ST_RUN} tbt_state_t;
endpackage : tbt_pkg

// ===== logic/tbt_baseline.sv
// Purpose: Reference tracking, ratiometric threshold and detect integrator of a touch sensor.
// Assumes: One raw burst result per raw_valid strobe; straps are static from power-up.
// Notes: Outputs ref, threshold and hysteresis lag the reference by one clock.
//
// What this block does
// (R1) Three gain levels chosen by a three-state strap: open, mid tie, low tie.
// (R2) An open strap selects high gain.
// (R3) Gain only changes the numeric threshold offset, not acquisition.
// (R4) All reference, threshold and drift arithmetic is 16 bits wide.
// (R5) Reference moves slowly toward raw signal only while nothing is detected.
// (R6) Reference steps are slew limited; threshold and hysteresis follow the reference.
// (R7) During a detection the reference is frozen.
// (R8) Reference follows falling signals faster than rising signals.
// (R9) Removed obstructions are tracked out quickly by the fast downward rate.
// (R10) Threshold is a fixed fraction above reference, recomputed continuously.
// (R11) Detection ends below threshold by half the reference to threshold delta.
// (R12) Four consecutive bursts above threshold declare detection; a miss clears count.
// (R13) Straps are sampled once after power-up only.
// (R14) Step sizes and intervals are parameters; downward rate well above upward.
`include "tbt_cfg.svh"

module tbt_baseline #(
  parameter int UP_STEP = `TBT_UP_STEP,
  parameter int DN_STEP = `TBT_DN_STEP,
  parameter int UP_INTERVAL = `TBT_UP_INTERVAL,
  parameter int DN_INTERVAL = `TBT_DN_INTERVAL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Burst results
  input wire logic raw_valid,
  input wire logic [15:0] raw_level,
  // Gain strap, already resolved into its two ties
  input wire logic strap_mid,
  input wire logic strap_low,
  // Results
  output logic detect,
  output logic [15:0] ref_level,
  output logic [15:0] thresh_level,
  output logic [15:0] hyst_level,
  output tbt_pkg::tbt_gain_t gain_level
);

  // A downward rate no faster than the upward one defeats obstruction recovery.
  if (UP_STEP < 1 || DN_STEP < 1 || UP_INTERVAL < 1 || DN_INTERVAL < 1 ||
      UP_INTERVAL > `TBT_INTERVAL_MAX || DN_INTERVAL > `TBT_INTERVAL_MAX ||
      DN_STEP * UP_INTERVAL <= UP_STEP * DN_INTERVAL ||
      UP_STEP > `TBT_MAX16 || DN_STEP > `TBT_MAX16) begin : g_bad_params // R14
    $error("tbt_baseline: unusable step or interval parameters");
  end

  localparam logic [15:0] UP_STEP_W = 16'(UP_STEP);
  localparam logic [15:0] DN_STEP_W = 16'(DN_STEP);
  localparam logic [7:0] UP_LAST = 8'(UP_INTERVAL - 1);
  localparam logic [7:0] DN_LAST = 8'(DN_INTERVAL - 1);
  localparam logic [2:0] CONF_LAST = 3'(`TBT_CONFIRM - 1);

  // ****************************************
  // Strap capture
  // ****************************************
  logic strap_taken_reg;
  tbt_pkg::tbt_gain_t gain_reg;

  // Caught at the first edge after reset release, never again.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken_reg <= 1'b0;
      gain_reg <= tbt_pkg::GAIN_HIGH;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1; // R13
      if (strap_low) begin
        gain_reg <= tbt_pkg::GAIN_LOW; // R1
      end else if (strap_mid) begin
        gain_reg <= tbt_pkg::GAIN_MED; // R1
      end else begin
        gain_reg <= tbt_pkg::GAIN_HIGH; // R2
      end
    end
  end

  // ****************************************
  // Threshold arithmetic
  // ****************************************
  tbt_pkg::tbt_state_t state_reg;
  logic [15:0] ref_reg;
  logic [15:0] delta;
  logic [16:0] thr_sum;
  logic [15:0] thr_now;
  logic [15:0] hyst_now;
  logic above;
  logic below_hyst;

  // A ratio of the absolute level keeps sensitivity constant as the load drifts.
  always_comb begin
    case (gain_reg)
      tbt_pkg::GAIN_MED: delta = ref_reg >> `TBT_SHIFT_MED; // R3
      tbt_pkg::GAIN_LOW: delta = ref_reg >> `TBT_SHIFT_LOW; // R3
      default: delta = ref_reg >> `TBT_SHIFT_HIGH; // R3
    endcase
    thr_sum = {1'b0, ref_reg} + {1'b0, delta}; // R4 R10
    thr_now = thr_sum[16] ? `TBT_MAX16 : thr_sum[15:0]; // R4
    hyst_now = thr_now - {1'b0, delta[15:1]}; // R11
    above = raw_level > thr_now;
    below_hyst = raw_level < hyst_now;
  end

  // ****************************************
  // Calibration state
  // ****************************************
  // The first burst after the straps are read becomes the reference.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= tbt_pkg::ST_CAL;
    end else begin
      case (state_reg)
        tbt_pkg::ST_CAL: if (strap_taken_reg && raw_valid) state_reg <= tbt_pkg::ST_RUN;
        default: state_reg <= tbt_pkg::ST_RUN;
      endcase
    end
  end

  wire run_burst = raw_valid && state_reg == tbt_pkg::ST_RUN;

  // ****************************************
  // Detect integrator
  // ****************************************
  logic detect_reg;
  logic [2:0] conf_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detect_reg <= 1'b0;
      conf_reg <= `TBT_CONF_ZERO;
    end else if (run_burst) begin
      if (detect_reg) begin
        conf_reg <= `TBT_CONF_ZERO;
        if (below_hyst) detect_reg <= 1'b0; // R11
      end else if (!above) begin
        conf_reg <= `TBT_CONF_ZERO; // R12
      end else if (conf_reg == CONF_LAST) begin
        detect_reg <= 1'b1; // R12
        conf_reg <= `TBT_CONF_ZERO;
      end else begin
        conf_reg <= conf_reg + 3'h1; // R12
      end
    end
  end

  // ****************************************
  // Drift compensation
  // ****************************************
  logic [7:0] up_cnt_reg;
  logic [7:0] dn_cnt_reg;
  logic [15:0] up_gap;
  logic [15:0] dn_gap;

  always_comb begin
    up_gap = raw_level - ref_reg;
    dn_gap = ref_reg - raw_level;
  end

  wire track = run_burst && !detect_reg; // R5 R7
  wire go_up = track && raw_level > ref_reg;
  wire go_dn = track && raw_level < ref_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt_reg <= `TBT_CNT_ZERO;
      dn_cnt_reg <= `TBT_CNT_ZERO;
    end else if (track) begin
      up_cnt_reg <= (!go_up || up_cnt_reg == UP_LAST) ? `TBT_CNT_ZERO : up_cnt_reg + 8'h01;
      dn_cnt_reg <= (!go_dn || dn_cnt_reg == DN_LAST) ? `TBT_CNT_ZERO : dn_cnt_reg + 8'h01;
    end
  end

  // Slow rise avoids absorbing an approaching finger before it touches.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_reg <= `TBT_ZERO16;
    end else if (state_reg == tbt_pkg::ST_CAL) begin
      if (strap_taken_reg && raw_valid) ref_reg <= raw_level;
    end else if (go_up && up_cnt_reg == UP_LAST) begin
      ref_reg <= ref_reg + ((up_gap < UP_STEP_W) ? up_gap : UP_STEP_W); // R5 R6 R8
    end else if (go_dn && dn_cnt_reg == DN_LAST) begin
      ref_reg <= ref_reg - ((dn_gap < DN_STEP_W) ? dn_gap : DN_STEP_W); // R6 R8 R9
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [15:0] thresh_reg;
  logic [15:0] hyst_reg;
  logic [15:0] ref_out_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thresh_reg <= `TBT_ZERO16;
      hyst_reg <= `TBT_ZERO16;
      ref_out_reg <= `TBT_ZERO16;
    end else begin
      thresh_reg <= thr_now; // R6 R10
      hyst_reg <= hyst_now; // R6 R11
      ref_out_reg <= ref_reg;
    end
  end

  assign detect = detect_reg;
  assign ref_level = ref_out_reg;
  assign thresh_level = thresh_reg;
  assign hyst_level = hyst_reg;
  assign gain_level = gain_reg;

  // ****************************************
  // Assertions
  // ****************************************
  // The gain ratio restated from the registered outputs, apart from the threshold path.
  logic [15:0] out_delta;

  always_comb begin
    if (gain_reg == tbt_pkg::GAIN_LOW) begin
      out_delta = ref_out_reg >> `TBT_SHIFT_LOW;
    end else if (gain_reg == tbt_pkg::GAIN_MED) begin
      out_delta = ref_out_reg >> `TBT_SHIFT_MED;
    end else begin
      out_delta = ref_out_reg >> `TBT_SHIFT_HIGH;
    end
  end

  a_detect_confirm: assert property (@(posedge clk) disable iff (!arst_n) // R12
    $rose(detect_reg) |-> $past(conf_reg) == CONF_LAST && $past(above) && $past(run_burst))
    else $error("detect rose without four confirmations");
  a_miss_clears: assert property (@(posedge clk) disable iff (!arst_n) // R12
    run_burst && !detect_reg && !above |=> conf_reg == `TBT_CONF_ZERO)
    else $error("missed burst did not clear the count");
  a_ref_frozen: assert property (@(posedge clk) disable iff (!arst_n) // R7
    detect_reg && state_reg == tbt_pkg::ST_RUN |=> $stable(ref_reg))
    else $error("reference moved during detection");
  a_up_slew: assert property (@(posedge clk) disable iff (!arst_n) // R6
    $past(state_reg) == tbt_pkg::ST_RUN && ref_reg > $past(ref_reg) |->
    ref_reg - $past(ref_reg) <= UP_STEP_W && $past(raw_valid))
    else $error("upward step too large");
  a_dn_slew: assert property (@(posedge clk) disable iff (!arst_n) // R6
    $past(state_reg) == tbt_pkg::ST_RUN && ref_reg < $past(ref_reg) |->
    $past(ref_reg) - ref_reg <= DN_STEP_W && ref_reg >= $past(raw_level))
    else $error("downward step too large or overshoots");
  a_dn_fast: assert property (@(posedge clk) disable iff (!arst_n) // R9
    go_dn && dn_cnt_reg == DN_LAST |=> ref_reg < $past(ref_reg))
    else $error("downward tracking stalled");
  a_thresh_track: assert property (@(posedge clk) disable iff (!arst_n) // R10
    ##1 thresh_reg >= ref_out_reg &&
    (thresh_reg == `TBT_MAX16 || thresh_reg - ref_out_reg == out_delta))
    else $error("threshold not slaved to reference");
  a_hyst_half: assert property (@(posedge clk) disable iff (!arst_n) // R11
    detect_reg && run_burst && raw_level >= hyst_now |=> detect_reg)
    else $error("detection dropped above hysteresis level");
  a_gain_hold: assert property (@(posedge clk) disable iff (!arst_n) // R13
    strap_taken_reg |=> $stable(gain_reg) && strap_taken_reg)
    else $error("gain changed after power-up");
  a_open_high: assert property (@(posedge clk) disable iff (!arst_n) // R2
    $rose(strap_taken_reg) && !$past(strap_mid) && !$past(strap_low) |->
    gain_reg == tbt_pkg::GAIN_HIGH)
    else $error("open strap did not select high gain");

  c_detect_on: cover property (@(posedge clk) disable iff (!arst_n) $rose(detect_reg));
  c_detect_off: cover property (@(posedge clk) disable iff (!arst_n) $fell(detect_reg));
  c_ref_down: cover property (@(posedge clk) disable iff (!arst_n)
    state_reg == tbt_pkg::ST_RUN && ref_reg < $past(ref_reg));
  c_gain_low: cover property (@(posedge clk) disable iff (!arst_n)
    strap_taken_reg && gain_reg == tbt_pkg::GAIN_LOW);

endmodule : tbt_baseline

// ===== sim/tbt_baseline_bench.sv
// Purpose: Self-checking bench for the touch baseline tracking block.
// Assumes: Default step and interval values, passed explicitly below.
// Notes: Each strap setting is taken through its own reset, as after a power cycle.
module tbt_baseline_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UPI = 16;
  localparam int DNS = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic raw_valid = 1'b0;
  logic [15:0] raw_level = 16'h0000;
  logic strap_mid = 1'b0;
  logic strap_low = 1'b0;
  logic detect;
  logic [15:0] ref_level;
  logic [15:0] thresh_level;
  logic [15:0] hyst_level;
  tbt_pkg::tbt_gain_t gain_level;
  int n_fail = 0;
  int total_checks = 0;
  integer seed = 32'h79c21525;
  logic [15:0] r;
  logic [15:0] d;
  logic [15:0] t;
  logic [15:0] h;
  int g;

  tbt_baseline #(.UP_STEP(1), .DN_STEP(DNS), .UP_INTERVAL(UPI), .DN_INTERVAL(1))
      tbt_baseline_inst (.clk(clk), .arst_n(arst_n), .raw_valid(raw_valid),
      .raw_level(raw_level), .strap_mid(strap_mid), .strap_low(strap_low), .detect(detect),
      .ref_level(ref_level), .thresh_level(thresh_level), .hyst_level(hyst_level),
      .gain_level(gain_level));

  always #50 clk = ~clk;

  // ****************************************
  // Expectations and checks
  // ****************************************
  function automatic logic [15:0] dlt(input logic [15:0] v, input int gs);
    return (gs == 0) ? (v >> 6) : (gs == 1) ? (v >> 5) : (v >> 4);
  endfunction : dlt

  function automatic logic [15:0] thr(input logic [15:0] v, input int gs);
    logic [16:0] s;
    s = {1'b0, v} + {1'b0, dlt(v, gs)};
    return s[16] ? 16'hffff : s[15:0];
  endfunction : thr

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  // Reference, threshold and hysteresis all derive from one expected reference.
  task automatic chk_ref(input logic [15:0] v, input int gs);
    chk("ref_level", v, ref_level);
    chk("thresh_level", thr(v, gs), thresh_level);
    chk("hyst_level", thr(v, gs) - (dlt(v, gs) >> 1), hyst_level);
  endtask : chk_ref

  // One burst, taken at the second edge; outputs are settled one edge later.
  task automatic burst(input logic [15:0] v);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_level <= v;
    @(posedge clk);
    raw_valid <= 1'b0;
    raw_level <= ~v;
    @(posedge clk);
    #1;
  endtask : burst

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      arst_n <= 1'b0;
      strap_mid <= (i == 1 || i == 3);
      strap_low <= (i >= 2);
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      g = (i >= 2) ? 2 : i;
      r = 16'h0400 + 16'($random(seed) & 16'h0fff);
      burst(r);
      chk_ref(r, g);
      @(posedge clk);
      strap_mid <= ~strap_mid;
      strap_low <= ~strap_low;
      for (int k = 0; k < 8; k++) begin
        d = 16'($random(seed) & 16'h001f);
        burst(r - d);
        r = r - ((d > 16'(DNS)) ? 16'(DNS) : d);
        chk_ref(r, g);
      end
      chk("gain_level", 16'(g), 16'(gain_level));
    end
    t = thr(r, g);
    h = t - (dlt(r, g) >> 1);
    repeat (3) burst(t + 16'h0001);
    burst(t);
    chk("detect", 16'h0000, 16'(detect));
    for (int k = 0; k < 4; k++) begin
      burst(t + 16'h0001);
      chk("detect", 16'(k == 3), 16'(detect));
    end
    burst(h);
    chk("detect", 16'h0001, 16'(detect));
    burst(16'hffff);
    chk_ref(r, g);
    burst(h - 16'h0001);
    chk("detect", 16'h0000, 16'(detect));
    chk_ref(r, g);
    burst(r);
    for (int k = 0; k < UPI; k++) begin
      burst(r + 16'h0002);
      chk("ref_level", (k == UPI - 1) ? r + 16'h0001 : r, ref_level);
    end
    chk("detect", 16'h0000, 16'(detect));
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule : tbt_baseline_bench
